// ### hdl/sfu_cfg.svh
`ifndef SFU_CFG_SVH
`define SFU_CFG_SVH

// Frame framing bytes
`define SFU_MARK 8'hAA
`define SFU_ESC 8'hAB
`define SFU_ESC_MARK 8'hAC

// Opcodes
`define SFU_OP_BEGIN 8'h01
`define SFU_OP_CRYPTO 8'h02
`define SFU_OP_IMAGE 8'h03
`define SFU_OP_CHECK 8'h04
`define SFU_OP_ACTIVATE 8'h05
`define SFU_OP_RESET 8'h06
`define SFU_OP_KEY 8'h09
`define SFU_OP_RESP 8'h10

// Status codes
`define SFU_ST_OK 8'h01
`define SFU_ST_STATE 8'h02
`define SFU_ST_PARAM 8'h03
`define SFU_ST_SIZE 8'h04
`define SFU_ST_CHECK 8'h05
`define SFU_ST_FAIL 8'h06
`define SFU_ST_MORE 8'h07

// Payload lengths in bytes
`define SFU_LEN_BEGIN 8'h0C
`define SFU_LEN_CRYPTO 8'h20
`define SFU_LEN_KEY 8'h5C
`define SFU_LEN_IMG_MIN 8'h04
`define SFU_LEN_IMG_MAX 8'hF8
`define SFU_LEN_RESP 8'h02
`define SFU_LEN_OVERHEAD 8'h02

// Reset values
`define SFU_BYTE_RST 8'h00
`define SFU_WORD_RST 32'h0000_0000

// Timing
`define SFU_TIMEOUT_S 10
`define SFU_CLK_HZ 10000000
`define SFU_TIMEOUT_CYC (`SFU_TIMEOUT_S * `SFU_CLK_HZ)

`endif

// ### hdl/sfu_pkg.sv
package sfu_pkg;

    typedef enum logic [4:0] {
        SQ_IDLE    = 5'b00001,
        SQ_BEGUN   = 5'b00010,
        SQ_LOADING = 5'b00100,
        SQ_LOADED  = 5'b01000,
        SQ_CHECKED = 5'b10000
    } sfu_seq_t;

    typedef enum logic [6:0] {
        FR_HUNT = 7'b0000001,
        FR_LEN  = 7'b0000010,
        FR_OP   = 7'b0000100,
        FR_DATA = 7'b0001000,
        FR_EXEC = 7'b0010000,
        FR_WAIT = 7'b0100000,
        FR_RESP = 7'b1000000
    } sfu_frame_t;

    typedef struct packed {
        logic [31:0] radioLen;
        logic [31:0] loaderLen;
        logic [31:0] appLen;
    } sfu_lens_t;

    typedef struct packed {
        logic [31:0] data;
        logic isKey;
    } sfu_word_t;

endpackage : sfu_pkg

// ### hdl/sfu_fifo.sv
`timescale 1ns/100ps
`default_nettype none

module sfu_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL_CNT = AW'(DEPTH - 1) + 1'b1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_ff;
    logic [AW-1:0] rdPtr_ff;
    logic [AW:0] count_ff;
    logic [AW:0] nxt_count;
    logic push;
    logic pop;

    // Output register is an extra stage, so the memory count alone decides full
    assign push = inValid && inReady;
    assign pop = (count_ff != '0) && (!outValid || outReady);

    always_comb begin
        nxt_count = count_ff;
        if (push && !pop) begin
            nxt_count = count_ff + 1'b1;
        end else if (pop && !push) begin
            nxt_count = count_ff - 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (ce && push) begin
            mem[wrPtr_ff] <= inData;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            count_ff <= '0;
            inReady <= 1'b0;
        end else if (ce) begin
            if (push) begin
                wrPtr_ff <= (wrPtr_ff == AW'(DEPTH - 1)) ? '0 : wrPtr_ff + 1'b1;
            end
            if (pop) begin
                rdPtr_ff <= (rdPtr_ff == AW'(DEPTH - 1)) ? '0 : rdPtr_ff + 1'b1;
            end
            count_ff <= nxt_count;
            inReady <= (nxt_count != FULL_CNT);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            outData <= '0;
            outValid <= 1'b0;
        end else if (ce) begin
            if (pop) begin
                outData <= mem[rdPtr_ff];
                outValid <= 1'b1;
            end else if (outReady) begin
                outValid <= 1'b0;
            end
        end
    end

endmodule : sfu_fifo

`default_nettype wire

// ### hdl/sfu_cmd_core.sv
// Behaviour
// - Answer each opcode except reset with status
// - Status codes one to seven as listed
// - Begin command first, three little-endian lengths
// - Radio update without loader update is refused
// - Crypto init only right after begin
// - Crypto payload: vector then tag, forwarded
// - Image data only after crypto init
// - Image payload 4..248 bytes, multiple of four
// - Report more-data until declared total arrives
// - Check only after full transfer; pass/fail
// - Activate answers then always resets
// - Reset command: reset at once, no answer
// - Application marked valid only at activate
// - Key provisioning 92 bytes, only when idle
// - Failed key check keeps old key, status five
// - Frame: marker, length, opcode, up to 253 bytes
// - Escaped marker and escape bytes in frames
// - Ten seconds idle during update resets
`timescale 1ns/100ps
`include "sfu_cfg.svh"
`default_nettype none

module sfu_cmd_core
    import sfu_pkg::*;
#(
    parameter int FIFO_DEPTH = 8,
    parameter int unsigned TIMEOUT_CYC = `SFU_TIMEOUT_CYC
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic loaderActive,
    input wire logic [7:0] rxByte,
    input wire logic rxValid,
    output logic rxReady,
    output logic [7:0] txByte,
    output logic txValid,
    input wire logic txReady,
    output sfu_lens_t regionLens,
    output logic regionLensValid,
    output logic [127:0] initVector,
    output logic [127:0] authTag,
    output logic cryptoInit,
    output sfu_word_t wordOut,
    output logic wordValid,
    output logic checkReq,
    input wire logic checkDone,
    input wire logic checkPass,
    output logic keyCheckReq,
    input wire logic keyDone,
    input wire logic keyPass,
    output logic keyCommit,
    output logic appActivate,
    output logic resetReq
);
    sfu_frame_t fr_ff;
    sfu_seq_t seq_ff;
    logic [7:0] fifoData, dataByte, len_ff, op_ff, idx_ff, verdict_ff, status_ff, execStatus, waitStatus;
    logic fifoValid, fifoReady, take, markSeen, escFF_ff, dataStb, waitDone, lastByte, fwdWord;
    logic [255:0] buf_ff;
    logic [23:0] acc_ff;
    logic [31:0] remain_ff, idle_ff;
    logic [1:0] respIdx_ff;

    sfu_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_rx_fifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .inData(rxByte),
        .inValid(rxValid),
        .inReady(rxReady),
        .outData(fifoData),
        .outValid(fifoValid),
        .outReady(fifoReady)
    );

    function automatic logic [7:0] len_check(input logic [7:0] got, input logic [7:0] want);
        if (got == want) begin
            return `SFU_ST_OK;
        end
        return (got > want) ? `SFU_ST_SIZE : `SFU_ST_PARAM;
    endfunction : len_check

    // Decided at the opcode byte so rejected payloads never reach the crypto side
    function automatic logic [7:0] pre_check(input logic [7:0] op, input logic [7:0] plen, input sfu_seq_t sq,
                                             input logic [31:0] remain);
        logic [7:0] res;
        res = `SFU_ST_OK;
        unique case (op)
            `SFU_OP_BEGIN: res = (sq != SQ_IDLE) ? `SFU_ST_STATE : len_check(plen, `SFU_LEN_BEGIN);
            `SFU_OP_CRYPTO: res = (sq != SQ_BEGUN) ? `SFU_ST_STATE : len_check(plen, `SFU_LEN_CRYPTO);
            `SFU_OP_IMAGE: begin
                if (sq != SQ_LOADING) begin
                    res = `SFU_ST_STATE;
                end else if (plen > `SFU_LEN_IMG_MAX || {24'h00_0000, plen} > remain) begin
                    res = `SFU_ST_SIZE;
                end else if (plen < `SFU_LEN_IMG_MIN || plen[1:0] != 2'b00) begin
                    res = `SFU_ST_PARAM;
                end
            end
            `SFU_OP_CHECK: res = (sq != SQ_LOADED) ? `SFU_ST_STATE : len_check(plen, `SFU_BYTE_RST);
            `SFU_OP_KEY: res = (sq != SQ_IDLE) ? `SFU_ST_STATE : len_check(plen, `SFU_LEN_KEY);
            `SFU_OP_ACTIVATE,
            `SFU_OP_RESET: res = `SFU_ST_OK;
            default: res = `SFU_ST_PARAM;
        endcase
        return res;
    endfunction : pre_check

    function automatic logic [7:0] resp_byte(input logic [1:0] pos, input logic [7:0] status);
        logic [7:0] res;
        unique case (pos)
            2'd0: res = `SFU_MARK;
            2'd1: res = `SFU_LEN_RESP;
            2'd2: res = `SFU_OP_RESP;
            2'd3: res = status;
        endcase
        return res;
    endfunction : resp_byte

    // Byte path and unescaping
    assign fifoReady = ce && !resetReq && (fr_ff inside {FR_HUNT, FR_LEN, FR_OP, FR_DATA});
    assign take = fifoValid && fifoReady;
    assign markSeen = take && (fifoData == `SFU_MARK);

    always_comb begin
        dataByte = fifoData;
        dataStb = take && !markSeen;
        if (escFF_ff) begin
            dataByte = (fifoData == `SFU_ESC_MARK) ? `SFU_MARK : fifoData;
        end else if (fifoData == `SFU_ESC) begin
            dataStb = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            escFF_ff <= 1'b0;
        end else if (ce) begin
            if (markSeen) begin
                escFF_ff <= 1'b0;
            end else if (take) begin
                escFF_ff <= !escFF_ff && (fifoData == `SFU_ESC);
            end
        end
    end

    assign lastByte = (idx_ff + 8'h01 == len_ff);
    assign fwdWord = dataStb && (fr_ff == FR_DATA) && (idx_ff[1:0] == 2'b11) && (verdict_ff == `SFU_ST_OK) &&
                     (op_ff == `SFU_OP_IMAGE || op_ff == `SFU_OP_KEY);

    // Outcome of a frame whose payload has fully arrived
    always_comb begin
        execStatus = verdict_ff;
        if (verdict_ff == `SFU_ST_OK) begin
            unique case (op_ff)
                `SFU_OP_BEGIN: begin
                    if (buf_ff[31:0] != '0 && buf_ff[63:32] == '0) begin
                        execStatus = `SFU_ST_PARAM;
                    end
                end
                `SFU_OP_IMAGE: execStatus = (remain_ff == '0) ? `SFU_ST_OK : `SFU_ST_MORE;
                `SFU_OP_ACTIVATE: execStatus = (seq_ff == SQ_CHECKED) ? `SFU_ST_OK : `SFU_ST_STATE;
                default: execStatus = `SFU_ST_OK;
            endcase
        end
    end
    assign waitDone = (op_ff == `SFU_OP_KEY) ? keyDone : checkDone;
    assign waitStatus = ((op_ff == `SFU_OP_KEY) ? keyPass : checkPass) ? `SFU_ST_OK : `SFU_ST_CHECK;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            fr_ff <= FR_HUNT;
            len_ff <= `SFU_BYTE_RST;
            op_ff <= `SFU_BYTE_RST;
            idx_ff <= `SFU_BYTE_RST;
            verdict_ff <= `SFU_ST_OK;
        end else if (ce) begin
            if (markSeen) begin
                // A taken marker restarts framing, even mid-frame, while loaderActive is high; otherwise it returns to hunting
                fr_ff <= loaderActive ? FR_LEN : FR_HUNT;
            end else begin
                unique case (fr_ff)
                    FR_HUNT: fr_ff <= FR_HUNT;
                    FR_LEN: begin
                        if (dataStb) begin
                            fr_ff <= (dataByte < `SFU_LEN_OVERHEAD) ? FR_HUNT : FR_OP;
                            len_ff <= dataByte - `SFU_LEN_OVERHEAD;
                        end
                    end
                    FR_OP: begin
                        if (dataStb) begin
                            op_ff <= dataByte;
                            idx_ff <= `SFU_BYTE_RST;
                            verdict_ff <= pre_check(dataByte, len_ff, seq_ff, remain_ff);
                            fr_ff <= (len_ff == '0) ? FR_EXEC : FR_DATA;
                        end
                    end
                    FR_DATA: begin
                        if (dataStb) begin
                            idx_ff <= idx_ff + 8'h01;
                            if (lastByte) begin
                                fr_ff <= FR_EXEC;
                            end
                        end
                    end
                    FR_EXEC: begin
                        if (op_ff == `SFU_OP_RESET) begin
                            fr_ff <= FR_HUNT;
                        end else if (verdict_ff == `SFU_ST_OK &&
                                     (op_ff == `SFU_OP_CHECK || op_ff == `SFU_OP_KEY)) begin
                            fr_ff <= FR_WAIT;
                        end else begin
                            fr_ff <= FR_RESP;
                        end
                    end
                    FR_WAIT: fr_ff <= waitDone ? FR_RESP : FR_WAIT;
                    FR_RESP: fr_ff <= (txReady && respIdx_ff == 2'd3) ? FR_HUNT : FR_RESP;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            seq_ff <= SQ_IDLE;
        end else if (ce) begin
            if (fr_ff == FR_EXEC && execStatus inside {`SFU_ST_OK, `SFU_ST_MORE}) begin
                unique case (op_ff)
                    `SFU_OP_BEGIN: seq_ff <= SQ_BEGUN;
                    `SFU_OP_CRYPTO: seq_ff <= SQ_LOADING;
                    `SFU_OP_IMAGE: seq_ff <= (remain_ff == '0) ? SQ_LOADED : SQ_LOADING;
                    default: seq_ff <= seq_ff;
                endcase
            end else if (fr_ff == FR_WAIT && waitDone && op_ff == `SFU_OP_CHECK) begin
                // A failed check forces the host to start over
                seq_ff <= checkPass ? SQ_CHECKED : SQ_IDLE;
            end
        end
    end

    // Payload capture, length bookkeeping and word forwarding
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            buf_ff <= '0;
            acc_ff <= '0;
            remain_ff <= `SFU_WORD_RST;
            wordOut <= '0;
            wordValid <= 1'b0;
        end else if (ce) begin
            wordValid <= fwdWord;
            if (dataStb && fr_ff == FR_DATA) begin
                if (idx_ff < `SFU_LEN_CRYPTO) begin
                    buf_ff[{idx_ff[4:0], 3'b000} +: 8] <= dataByte;
                end
                acc_ff <= {dataByte, acc_ff[23:8]};
            end
            if (fwdWord) begin
                wordOut <= '{data: {dataByte, acc_ff}, isKey: (op_ff == `SFU_OP_KEY)};
                if (op_ff == `SFU_OP_IMAGE) begin
                    remain_ff <= remain_ff - 32'h0000_0004;
                end
            end else if (fr_ff == FR_EXEC && op_ff == `SFU_OP_BEGIN && execStatus == `SFU_ST_OK) begin
                remain_ff <= buf_ff[31:0] + buf_ff[63:32] + buf_ff[95:64];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            regionLens <= '0;
            regionLensValid <= 1'b0;
            initVector <= '0;
            authTag <= '0;
            cryptoInit <= 1'b0;
            checkReq <= 1'b0;
            keyCheckReq <= 1'b0;
            keyCommit <= 1'b0;
            appActivate <= 1'b0;
        end else if (ce) begin
            regionLensValid <= 1'b0;
            cryptoInit <= 1'b0;
            checkReq <= 1'b0;
            keyCheckReq <= 1'b0;
            keyCommit <= 1'b0;
            appActivate <= 1'b0;
            if (fr_ff == FR_EXEC && execStatus == `SFU_ST_OK) begin
                unique case (op_ff)
                    `SFU_OP_BEGIN: begin
                        regionLens <= '{radioLen: buf_ff[31:0], loaderLen: buf_ff[63:32], appLen: buf_ff[95:64]};
                        regionLensValid <= 1'b1;
                    end
                    `SFU_OP_CRYPTO: begin
                        initVector <= buf_ff[127:0];
                        authTag <= buf_ff[255:128];
                        cryptoInit <= 1'b1;
                    end
                    `SFU_OP_CHECK: checkReq <= 1'b1;
                    `SFU_OP_KEY: keyCheckReq <= 1'b1;
                    `SFU_OP_ACTIVATE: appActivate <= 1'b1;
                    default: appActivate <= 1'b0;
                endcase
            end
            if (fr_ff == FR_WAIT && keyDone && keyPass && op_ff == `SFU_OP_KEY) begin
                keyCommit <= 1'b1;
            end
        end
    end

    // Status response frame; its bytes never need escaping
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            txByte <= `SFU_BYTE_RST;
            txValid <= 1'b0;
            respIdx_ff <= 2'd0;
            status_ff <= `SFU_ST_OK;
        end else if (ce) begin
            if ((fr_ff == FR_EXEC && op_ff != `SFU_OP_RESET && fr_ff != FR_WAIT &&
                 !(verdict_ff == `SFU_ST_OK && (op_ff == `SFU_OP_CHECK || op_ff == `SFU_OP_KEY))) ||
                (fr_ff == FR_WAIT && waitDone)) begin
                status_ff <= (fr_ff == FR_WAIT) ? waitStatus : execStatus;
                txByte <= `SFU_MARK;
                txValid <= 1'b1;
                respIdx_ff <= 2'd0;
            end else if (fr_ff == FR_RESP && txReady) begin
                if (respIdx_ff == 2'd3) begin
                    txValid <= 1'b0;
                end else begin
                    txByte <= resp_byte(respIdx_ff + 2'd1, status_ff);
                    respIdx_ff <= respIdx_ff + 2'd1;
                end
            end
        end
    end

    // Reset request: reset command, end of activate, or inactivity during an update
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            idle_ff <= '0;
            resetReq <= 1'b0;
        end else if (ce) begin
            if (seq_ff == SQ_IDLE || fr_ff == FR_EXEC) begin
                idle_ff <= '0;
            end else begin
                idle_ff <= idle_ff + 32'h0000_0001;
            end
            if (fr_ff == FR_EXEC && op_ff == `SFU_OP_RESET) begin
                resetReq <= 1'b1;
            end else if (fr_ff == FR_RESP && txReady && respIdx_ff == 2'd3 && op_ff == `SFU_OP_ACTIVATE) begin
                resetReq <= 1'b1;
            end else if (idle_ff == TIMEOUT_CYC - 1) begin
                resetReq <= 1'b1;
            end
        end
    end

endmodule : sfu_cmd_core

`default_nettype wire

// ### testbench/sfu_cmd_assertions.sv
`timescale 1ns/100ps
`default_nettype none

module sfu_cmd_assertions
    import sfu_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] txByte,
    input wire logic txValid,
    input wire logic txReady,
    input wire sfu_lens_t regionLens,
    input wire logic regionLensValid,
    input wire logic cryptoInit,
    input wire sfu_word_t wordOut,
    input wire logic wordValid,
    input wire logic checkReq,
    input wire logic keyDone,
    input wire logic keyPass,
    input wire logic keyCommit,
    input wire logic appActivate,
    input wire logic resetReq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    logic begunFf;
    logic cryptoFf;

    always_ff @(posedge clk_sys) begin
        if (rst) begunFf <= 1'b0;
        else if (regionLensValid) begunFf <= 1'b1;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) cryptoFf <= 1'b0;
        else if (cryptoInit) cryptoFf <= 1'b1;
    end

    tx_hold_a: assert property (txValid && !txReady |=> txValid && $stable(txByte))
        else $error("response byte changed before taken");
    tx_code_a: assert property (txValid |-> txByte inside {8'hAA, 8'h10, [8'h01:8'h07]})
        else $error("illegal response byte");
    begin_answer_a: assert property (regionLensValid |-> ##[0:3] (txValid && txByte == 8'hAA))
        else $error("no response after begin");
    radio_loader_a: assert property (regionLensValid |-> regionLens.radioLen == 0 || regionLens.loaderLen != 0)
        else $error("radio update accepted without loader");
    crypto_order_a: assert property (cryptoInit |-> begunFf)
        else $error("crypto init before begin");
    image_order_a: assert property (wordValid && !wordOut.isKey |-> cryptoFf)
        else $error("image word before crypto init");
    check_order_a: assert property (checkReq |-> cryptoFf)
        else $error("check before transfer");
    key_commit_a: assert property ($rose(keyCommit) |-> $past(keyDone && keyPass))
        else $error("key commit without passing check");
    reset_sticky_a: assert property (resetReq |=> resetReq)
        else $error("reset request dropped");
    activate_reset_a: assert property (appActivate |-> ##[0:300] resetReq)
        else $error("no reset after activate");

    begin_c: cover property (regionLensValid);
    activate_c: cover property (appActivate);
    key_c: cover property (keyCommit);
endmodule : sfu_cmd_assertions

bind sfu_cmd_core sfu_cmd_assertions chk_i (.clk_sys, .rst, .txByte, .txValid, .txReady, .regionLens,
    .regionLensValid, .cryptoInit, .wordOut, .wordValid, .checkReq, .keyDone, .keyPass, .keyCommit,
    .appActivate, .resetReq);

`default_nettype wire

// ### testbench/sfu_host_sink.sv
`timescale 1ns/100ps
`default_nettype none

module sfu_host_sink (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] txByte,
    input wire logic txValid,
    output logic txReady,
    output logic [7:0] statusByte,
    output logic statusValid,
    output logic frameOk
);
    int idx = 0;
    int seed = 32'h5ccd_d5b0;
    logic okAcc = 1'b1;

    initial begin
        txReady = 1'b0;
        statusByte = 8'h00;
        statusValid = 1'b0;
        frameOk = 1'b0;
    end

    // Host stalls about one byte in four so the sender must hold each byte
    always @(posedge clk_sys) begin
        statusValid <= 1'b0;
        if (rst) begin
            idx = 0;
        end else if (txValid && txReady) begin
            case (idx)
                0: okAcc = (txByte == 8'hAA);
                1: okAcc = okAcc && (txByte == 8'h02);
                2: okAcc = okAcc && (txByte == 8'h10);
                default: begin
                    statusByte <= txByte;
                    statusValid <= 1'b1;
                    frameOk <= okAcc;
                end
            endcase
            idx = (idx + 1) % 4;
        end
        txReady <= ({$random(seed)} % 4) != 0;
    end
endmodule : sfu_host_sink

`default_nettype wire

// ### testbench/serial_firmware_update_cmds_bench.sv
`timescale 1ns/100ps
`default_nettype none

module serial_firmware_update_cmds_bench
    import sfu_pkg::*;
;
    logic clk_sys = 0, rst = 1, ce = 1, loaderActive = 1, rxValid = 0;
    logic checkDone = 0, checkPass = 0, keyDone = 0, keyPass = 0;
    logic [7:0] rxByte = 8'h00, txByte, statusByte, expSt;
    logic rxReady, txValid, txReady, regionLensValid, cryptoInit, wordValid, checkReq, keyCheckReq;
    logic keyCommit, appActivate, resetReq, statusValid, frameOk;
    logic [127:0] initVector, authTag;
    sfu_lens_t regionLens;
    sfu_word_t wordOut;
    logic [7:0] pay [0:251];
    logic [7:0] expQ [$];
    int num_errors = 0, total_checks = 0, cycles = 0, seed = 32'h5ccd_d5b0;

    sfu_cmd_core #(.FIFO_DEPTH(8), .TIMEOUT_CYC(400)) dut (.clk_sys, .rst, .ce, .loaderActive, .rxByte,
        .rxValid, .rxReady, .txByte, .txValid, .txReady, .regionLens, .regionLensValid, .initVector,
        .authTag, .cryptoInit, .wordOut, .wordValid, .checkReq, .checkDone, .checkPass, .keyCheckReq,
        .keyDone, .keyPass, .keyCommit, .appActivate, .resetReq);
    sfu_host_sink host (.clk_sys, .rst, .txByte, .txValid, .txReady, .statusByte, .statusValid, .frameOk);

    initial begin
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task print_verdict;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict

    task automatic putB(input logic [7:0] b);
        rxByte = b;
        rxValid = 1'b1;
        do @(posedge clk_sys); while (rxReady !== 1'b1);
        #1;
    endtask : putB

    task automatic putE(input logic [7:0] b);
        if (b == 8'hAA || b == 8'hAB) begin
            putB(8'hAB);
            putB(b == 8'hAA ? 8'hAC : 8'hAB);
        end else begin
            putB(b);
        end
    endtask : putE

    task automatic sendFrame(input logic [7:0] op, input int n, input logic [7:0] st);
        putB(8'hAA);
        putE(8'(n + 2));
        putE(op);
        for (int i = 0; i < n; i++) putE(pay[i]);
        rxValid = 1'b0;
        if (op != 8'h06) expQ.push_back(st);
        for (int k = 0; k < 3000 && expQ.size() != 0; k++) @(posedge clk_sys);
        #1;
        chk("pending", 0, expQ.size());
    endtask : sendFrame

    task automatic rnd(input int n);
        for (int i = 0; i < n; i++) pay[i] = 8'($random(seed));
    endtask : rnd

    task automatic setLens(input logic [31:0] r, input logic [31:0] l, input logic [31:0] a);
        for (int i = 0; i < 4; i++) begin
            pay[i] = r[8*i+:8];
            pay[4+i] = l[8*i+:8];
            pay[8+i] = a[8*i+:8];
        end
    endtask : setLens

    task automatic doReset;
        rst = 1'b1;
        repeat (5) @(posedge clk_sys);
        #1;
        rst = 1'b0;
    endtask : doReset

    always @(posedge clk_sys) begin
        checkDone <= checkReq;
        keyDone <= keyCheckReq;
        if (statusValid) begin
            if (expQ.size() == 0) begin
                num_errors++;
                $display("BAD status expected none seen %h", statusByte);
            end else begin
                expSt = expQ.pop_front();
                chk("status", expSt, statusByte);
                chk("frame", 1, frameOk);
            end
        end
        cycles++;
        if (cycles == 30000) begin
            num_errors++;
            $display("BAD cycles expected under 30000 seen %0d", cycles);
            print_verdict;
        end
    end

    initial begin
        doReset();
        rnd(32);
        sendFrame(8'h02, 32, 8'h02);
        sendFrame(8'h03, 4, 8'h02);
        sendFrame(8'h04, 0, 8'h02);
        sendFrame(8'h08, 0, 8'h03);
        sendFrame(8'h07, 0, 8'h03);
        $display("done: order");
        for (int i = 12; i < 92; i++) pay[i] = {8{i > 59 && i < 76}};
        setLens(32'h0000_0030, '0, '0);
        keyPass = 1'b1;
        sendFrame(8'h09, 92, 8'h01);
        keyPass = 1'b0;
        sendFrame(8'h09, 92, 8'h05);
        sendFrame(8'h09, 91, 8'h03);
        setLens(32'h0000_0004, 32'h0000_0000, 32'h0000_0008);
        sendFrame(8'h01, 12, 8'h03);
        sendFrame(8'h01, 11, 8'h03);
        $display("done: keys");
        setLens(32'h0000_0000, 32'h0000_0000, 32'h0000_0104);
        sendFrame(8'h01, 12, 8'h01);
        chk("appLen", 32'h0000_0104, regionLens.appLen);
        sendFrame(8'h09, 92, 8'h02);
        sendFrame(8'h03, 4, 8'h02);
        rnd(32);
        sendFrame(8'h02, 32, 8'h01);
        chk("vector", {pay[3], pay[2], pay[1], pay[0]}, initVector[31:0]);
        chk("tag", {pay[19], pay[18], pay[17], pay[16]}, authTag[31:0]);
        rnd(252);
        sendFrame(8'h03, 252, 8'h04);
        sendFrame(8'h03, 5, 8'h03);
        sendFrame(8'h03, 248, 8'h07);
        sendFrame(8'h03, 12, 8'h01);
        chk("word", {pay[11], pay[10], pay[9], pay[8]}, wordOut.data);
        checkPass = 1'b1;
        sendFrame(8'h04, 0, 8'h01);
        sendFrame(8'h05, 0, 8'h01);
        repeat (3) @(posedge clk_sys);
        chk("reset", 1, resetReq);
        $display("done: full update");
        doReset();
        setLens(32'h0000_0000, 32'h0000_0000, 32'h0000_0004);
        sendFrame(8'h01, 12, 8'h01);
        sendFrame(8'h02, 32, 8'h01);
        sendFrame(8'h03, 4, 8'h01);
        checkPass = 1'b0;
        sendFrame(8'h04, 0, 8'h05);
        sendFrame(8'h05, 0, 8'h02);
        repeat (3) @(posedge clk_sys);
        chk("reset", 1, resetReq);
        $display("done: failed check");
        doReset();
        loaderActive = 1'b0;
        repeat (2) begin
            sendFrame(8'h06, 0, 8'h00);
            repeat (20) @(posedge clk_sys);
            chk("reset", loaderActive, resetReq);
            loaderActive = 1'b1;
        end
        $display("done: reset command");
        doReset();
        setLens(32'h0000_0000, 32'h0000_0000, 32'h0000_0004);
        sendFrame(8'h01, 12, 8'h01);
        repeat (350) @(posedge clk_sys);
        chk("early", 0, resetReq);
        repeat (150) @(posedge clk_sys);
        chk("timeout", 1, resetReq);
        $display("done: idle timeout");
        print_verdict;
    end
endmodule : serial_firmware_update_cmds_bench

`default_nettype wire
